// ---- hdl/bfps_pgood.sv ----
// bfps per-channel power-good flag with fall deglitch and rise validation
`timescale 1ns/100ps
module bfps_pgood #(
  parameter int DEGL_CYC = 500,
  parameter int VAL_CYC  = 10000
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pg_rise,
  input  wire logic pg_fall,
  output logic      flag_q,
  output logic      valid
);
  logic [15:0] degl_q;  // time spent below the low threshold
  logic [15:0] val_q;   // time the flag has been high
  logic        done_q;  // validation time reached

  // flag rises at once, falls only after a held low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
      degl_q <= 16'h0000;
    end else if (!pg_fall) begin
      degl_q <= 16'h0000;
      if (pg_rise) begin
        flag_q <= 1'b1;
      end
    end else if (degl_q >= 16'(DEGL_CYC)) begin
      // more than the deglitch time below threshold
      flag_q <= 1'b0;
    end else begin
      degl_q <= degl_q + 16'h0001;
    end
  end

  // validation timer restarts whenever the flag drops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      val_q  <= 16'h0000;
      done_q <= 1'b0;
    end else if (!flag_q) begin
      val_q  <= 16'h0000;
      done_q <= 1'b0;
    end else if (val_q >= 16'(VAL_CYC - 1)) begin
      done_q <= 1'b1;
    end else begin
      val_q <= val_q + 16'h0001;
    end
  end

  // falls in the same cycle as the flag, no validation delay on the way down
  assign valid = flag_q & done_q;
endmodule

// ---- hdl/bfps_pkg.sv ----
// bfps shared types: channel states, limit settings, comparator bundle
package bfps_pkg;
  // per-channel sequencing state
  typedef enum logic [2:0] {
    CH_OFF,
    CH_SS,
    CH_RUN,
    CH_HIC,
    CH_LATCH
  } bfps_ch_e;
  // peak current limit setting sent to the analog stage
  typedef enum logic [1:0] {
    ILIM_4A40,
    ILIM_2A63,
    ILIM_6A44
  } bfps_ilim_e;
  // analog comparator results of one channel
  typedef struct packed {
    logic ilim_hit;
    logic pwm_end;
    logic fb_lt_half;
    logic fb_lt_quarter;
    logic duty_max;
    logic duty_over;
    logic ovp;
    logic vin_rise;
    logic vin_fall;
    logic pg_rise;
    logic pg_fall;
    logic ref_above_fb;
  } bfps_cmp_s;
endpackage

// ---- hdl/bfps_regs.svh ----
// bfps offsets, fields, resets and timings
`ifndef BFPS_REGS_SVH
`define BFPS_REGS_SVH
// apb byte offsets
`define BFPS_CFG_OFS      8'h00
`define BFPS_STAT_OFS     8'h04
`define BFPS_STRAP_OFS    8'h08
`define BFPS_FLT_OFS      8'h0C
// cfg fields
`define BFPS_CFG_HIC_BIT  0
`define BFPS_CFG_SCL_BIT  1
`define BFPS_CFG_OVL_BIT  2
`define BFPS_CFG_PGS_LSB  4
`define BFPS_CFG_LOCK_BIT 31
`define BFPS_CFG_MASK     32'h8000_00F7
`define BFPS_CFG_RST      32'h0000_0011
// stat fields
`define BFPS_STAT_PGF_LSB 12
`define BFPS_STAT_PG_BIT  16
`define BFPS_STAT_TSD_BIT 17
`define BFPS_STAT_VOK_LSB 18
`define BFPS_STAT_SUP_BIT 22
// strap, fault fields
`define BFPS_STRAP_IL_LSB 8
`define BFPS_FLT_RTY_LSB  16
// logic clock rate
`define BFPS_CLK_HZ       10000000
// pg fall deglitch, us
`define BFPS_PG_DEGL_US   50
`define BFPS_PG_DEGL_CYC  ((`BFPS_PG_DEGL_US * `BFPS_CLK_HZ) / 1000000)
// pg rise validation, ms
`define BFPS_PG_VAL_MS    1
`define BFPS_PG_VAL_CYC   ((`BFPS_PG_VAL_MS * `BFPS_CLK_HZ) / 1000)
// base soft start, ms; 4 and 8 ms are shifts
`define BFPS_SS_MS        2
`define BFPS_SS_CYC       ((`BFPS_SS_MS * `BFPS_CLK_HZ) / 1000)
// fault counter top, restart limit, hiccup wait in soft starts
`define BFPS_FAULT_MAX    4'hF
`define BFPS_RETRY_MAX    3'h7
`define BFPS_HIC_MULT     7
// soft start select, 2 bits per strap level
`define BFPS_SS_TBL_CH1   16'hA940
`define BFPS_SS_TBL_CH2   16'h8120
`define BFPS_SS_TBL_CH3   16'hA540
`define BFPS_SS_TBL_CH4   16'h8924
`endif

// ---- hdl/bfps_sync.sv ----
// bfps two-flop synchroniser for a vector of levels
`timescale 1ns/100ps
module bfps_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;  // first stage, read only by q

  // two stages; nothing else may look at meta_q
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// ---- hdl/bfps_top.sv ----
// bfps top: four buck channel protection sequencer with apb registers
//
// Overview of operation
// (RULE1) block low-side until reference passes feedback
// (RULE2) current limit ends high-side for cycle
// (RULE3) decode limit strap for channels one, two
// (RULE4) feedback below half halves frequency
// (RULE5) feedback below quarter quarters frequency
// (RULE6) maximum duty skips every second pulse
// (RULE7) beyond maximum duty skips two of three
// (RULE8) fifteen limited cycles overflow, both switches off
// (RULE9) hiccup waits seven soft starts, then restarts
// (RULE10) restart resumes, or hiccups again after soft start
// (RULE11) hiccup masked during first soft start
// (RULE12) one hiccup enable; foldback always stays
// (RULE13) seven failed restarts latch channel off
// (RULE14) latch clears only by enable or supply
// (RULE15) short latch needs hiccup enabled
// (RULE16) overvoltage latches channel off when enabled
// (RULE17) input undervoltage lockout gates soft start
// (RULE18) channel one lockout holds all others
// (RULE19) channel flag rises fast, falls after deglitch
// (RULE20) power good ands selected validated flags
// (RULE21) thermal shutdown stops all, restarts soft
// (RULE22) supervisor active only with any enable
// (RULE23) soft start 2, 4, 8 ms by strap
// (RULE24) comparator results synchronised before use
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`include "bfps_regs.svh"
module bfps_top #(
  parameter int SS_CYC   = `BFPS_SS_CYC,
  parameter int PG_VAL   = `BFPS_PG_VAL_CYC,
  parameter int PG_DEGL  = `BFPS_PG_DEGL_CYC
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     sw_tick,
  input  wire bfps_pkg::bfps_cmp_s [3:0] cmp,
  input  wire logic [3:0]               channel_enable_pin,
  input  wire logic                     tsd_hot,
  input  wire logic                     tsd_cool,
  input  wire logic [3:0]               current_limit_strap,
  input  wire logic [2:0]               soft_start_strap_ch12,
  input  wire logic [2:0]               soft_start_strap_ch34,
  output logic      [3:0]               hs_on,
  output logic      [3:0]               ls_on,
  output logic      [3:0]               reverse_block,
  output logic      [3:0]               ss_active,
  output logic      [3:0]               current_limit_setting,
  output logic                          power_good_output,
  output logic                          supervisor_active
);
  localparam int CW = $bits(bfps_pkg::bfps_cmp_s);

  // synchronised analog results
  bfps_pkg::bfps_cmp_s [3:0] cmp_s; // per-channel comparators
  logic [3:0]  en_s; // channel enables
  logic        hot_s; // over 150 C
  logic        cool_s; // under 135 C

  // configuration and straps
  logic [31:0] cfg_q; // one-time configuration word
  logic        cap_q; // straps already captured
  logic [1:0]  ss_sel_q [4]; // 0 = 2 ms, 1 = 4 ms, 2 = 8 ms

  // protection state
  logic [3:0]  vok_q; // input above lockout, per channel
  logic        tsd_q; // thermal shutdown held
  bfps_pkg::bfps_ch_e st_q [4]; // channel state
  bfps_pkg::bfps_ch_e st_d [4];
  logic [23:0] tmr_q [4]; // soft start and hiccup timer
  logic [23:0] tmr_d [4];
  logic [3:0]  fcnt_q [4]; // overcurrent fault counter
  logic [2:0]  rty_q [4]; // consecutive restart attempts
  logic [1:0]  ph_q [4]; // pulse skip phase
  logic [3:0]  first_q; // in first soft start after enable
  logic [3:0]  flt_q; // fault seen during restart
  logic [3:0]  cut_q; // current limit hit this cycle

  // derived per-channel terms
  logic [3:0]  act; // switching allowed
  logic [3:0]  go; // may run
  logic [3:0]  trip; // counter overflow that counts
  logic [3:0]  ovl; // overvoltage latch event
  logic [3:0]  fire; // new high-side pulse
  logic [3:0]  rb_d; // next reverse block, shared by both gate flops
  logic [23:0] len [4]; // soft start length in cycles

  // power good
  logic [3:0]  pg_flag;
  logic [3:0]  pg_val;

  // apb read path
  logic [31:0] rd_d;
  logic        hit_d;

  // soft start length, doubled per select step
  function automatic logic [23:0] ss_len_f(input logic [1:0] sel);
    return 24'(SS_CYC) << sel;
  endfunction

  // strap level to soft start select through a packed table
  function automatic logic [1:0] ss_sel_f(input logic [15:0] tbl,
                                          input logic [2:0]  lvl);
    return tbl[{lvl, 1'b0} +: 2];
  endfunction

  // limit strap: open, 47 k or 22 k to ground
  function automatic bfps_pkg::bfps_ilim_e ilim_f(input logic [1:0] code);
    case (code)
      2'h1:    return bfps_pkg::ILIM_2A63;
      2'h2:    return bfps_pkg::ILIM_6A44;
      default: return bfps_pkg::ILIM_4A40;
    endcase
  endfunction

  // foldback and pulse skip divider; short circuit foldback outranks skip
  function automatic logic [1:0] div_f(input bfps_pkg::bfps_cmp_s c);
    if (c.fb_lt_quarter) begin
      return 2'h3; // one pulse in four
    end else if (c.fb_lt_half) begin
      return 2'h1; // one pulse in two
    end else if (c.duty_over) begin
      return 2'h2; // one pulse in three
    end else if (c.duty_max) begin
      return 2'h1; // every other pulse
    end
    return 2'h0;
  endfunction

  // comparator, enable and thermal levels pass two flops first; the straps do not
  bfps_sync #(
    .W (CW * 4 + 6)
  ) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     ({cmp, channel_enable_pin, tsd_hot, tsd_cool}),
    .q     ({cmp_s, en_s, hot_s, cool_s}) // (RULE24)
  );

  // one deglitch and validation unit per channel
  for (genvar g = 0; g < 4; g++) begin : g_pg
    bfps_pgood #(
      .DEGL_CYC (PG_DEGL),
      .VAL_CYC  (PG_VAL)
    ) u_pg (
      .clk     (pclk),
      .rst_n   (presetn),
      .pg_rise (cmp_s[g].pg_rise),
      .pg_fall (cmp_s[g].pg_fall),
      .flag_q  (pg_flag[g]), // (RULE19)
      .valid   (pg_val[g])
    );
  end

  // straps are sampled once, one clock after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_q                 <= 1'b0;
      current_limit_setting <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        ss_sel_q[i] <= 2'h0;
      end
    end else if (!cap_q) begin
      cap_q                      <= 1'b1;
      current_limit_setting[1:0] <= ilim_f(current_limit_strap[1:0]); // (RULE3)
      current_limit_setting[3:2] <= ilim_f(current_limit_strap[3:2]); // (RULE3)
      ss_sel_q[0] <= ss_sel_f(`BFPS_SS_TBL_CH1, soft_start_strap_ch12); // (RULE23)
      ss_sel_q[1] <= ss_sel_f(`BFPS_SS_TBL_CH2, soft_start_strap_ch12); // (RULE23)
      ss_sel_q[2] <= ss_sel_f(`BFPS_SS_TBL_CH3, soft_start_strap_ch34); // (RULE23)
      ss_sel_q[3] <= ss_sel_f(`BFPS_SS_TBL_CH4, soft_start_strap_ch34); // (RULE23)
    end
  end

  // input lockout hysteresis and thermal hysteresis
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vok_q <= 4'h0;
      tsd_q <= 1'b0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (cmp_s[i].vin_fall) begin
          vok_q[i] <= 1'b0; // below 3.78 V (RULE17)
        end else if (cmp_s[i].vin_rise) begin
          vok_q[i] <= 1'b1; // above 4.2 V (RULE17)
        end
      end
      if (hot_s) begin
        tsd_q <= 1'b1; // (RULE21)
      end else if (cool_s) begin
        tsd_q <= 1'b0; // (RULE21)
      end
    end
  end

  // per-channel qualifiers
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      act[i]  = (st_q[i] == bfps_pkg::CH_SS) || (st_q[i] == bfps_pkg::CH_RUN);
      // channel one supply gates every channel
      go[i]   = en_s[i] & vok_q[i] & vok_q[0] & ~tsd_q; // (RULE17) (RULE18) (RULE21)
      trip[i] = sw_tick & act[i] & cut_q[i] & (fcnt_q[i] == `BFPS_FAULT_MAX)
                & cfg_q[`BFPS_CFG_HIC_BIT] & ~first_q[i]; // (RULE8) (RULE11) (RULE12)
      ovl[i]  = act[i] & cfg_q[`BFPS_CFG_OVL_BIT] & cmp_s[i].ovp; // (RULE16)
      fire[i] = sw_tick & act[i] & (ph_q[i] == 2'h0);
      rb_d[i] = (st_q[i] == bfps_pkg::CH_SS) & ~cmp_s[i].ref_above_fb; // (RULE1)
      len[i]  = ss_len_f(ss_sel_q[i]);
    end
  end

  // channel sequencing next state
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      st_d[i]  = st_q[i];
      tmr_d[i] = tmr_q[i] + 24'h000001;
      case (st_q[i])
        bfps_pkg::CH_OFF: begin
          tmr_d[i] = 24'h000000;
          if (go[i]) begin
            st_d[i] = bfps_pkg::CH_SS;
          end
        end
        bfps_pkg::CH_SS: begin
          if (!go[i]) begin
            st_d[i] = bfps_pkg::CH_OFF;
          end else if (ovl[i]) begin
            st_d[i] = bfps_pkg::CH_LATCH;           // (RULE16)
          end else if (tmr_q[i] >= len[i] - 24'h000001) begin
            tmr_d[i] = 24'h000000;
            if (flt_q[i] | trip[i]) begin
              // flt only sets with hiccup on, so the latch needs it too
              if (cfg_q[`BFPS_CFG_SCL_BIT] && rty_q[i] == `BFPS_RETRY_MAX) begin
                st_d[i] = bfps_pkg::CH_LATCH;       // (RULE13) (RULE15)
              end else begin
                st_d[i] = bfps_pkg::CH_HIC;         // (RULE10)
              end
            end else begin
              st_d[i] = bfps_pkg::CH_RUN;           // (RULE10)
            end
          end
        end
        bfps_pkg::CH_RUN: begin
          tmr_d[i] = 24'h000000;
          if (!go[i]) begin
            st_d[i] = bfps_pkg::CH_OFF;
          end else if (ovl[i]) begin
            st_d[i] = bfps_pkg::CH_LATCH;           // (RULE16)
          end else if (trip[i]) begin
            st_d[i] = bfps_pkg::CH_HIC;             // (RULE8)
          end
        end
        bfps_pkg::CH_HIC: begin
          if (!go[i]) begin
            st_d[i] = bfps_pkg::CH_OFF;
          end else if (tmr_q[i] >= 24'(len[i] * `BFPS_HIC_MULT) - 24'h000001) begin
            tmr_d[i] = 24'h000000;
            st_d[i]  = bfps_pkg::CH_SS;             // (RULE9)
          end
        end
        bfps_pkg::CH_LATCH: begin
          // thermal events do not clear the latch, only enable or supply
          tmr_d[i] = 24'h000000;
          if (!en_s[i] || !vok_q[i]) begin
            st_d[i] = bfps_pkg::CH_OFF;             // (RULE14)
          end
        end
        default: begin
          st_d[i]  = bfps_pkg::CH_OFF;
          tmr_d[i] = 24'h000000;
        end
      endcase
    end
  end

  // state and timer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        st_q[i]  <= bfps_pkg::CH_OFF;
        tmr_q[i] <= 24'h000000;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        st_q[i]  <= st_d[i];
        tmr_q[i] <= tmr_d[i];
      end
    end
  end

  // first soft start mask, restart fault flag and attempt count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_q <= 4'h0;
      flt_q   <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        rty_q[i] <= 3'h0;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (st_q[i] == bfps_pkg::CH_OFF && go[i]) begin
          first_q[i] <= 1'b1; // (RULE11)
        end else if (st_q[i] == bfps_pkg::CH_SS && st_d[i] != bfps_pkg::CH_SS) begin
          first_q[i] <= 1'b0;
        end
        if (st_q[i] != bfps_pkg::CH_SS) begin
          flt_q[i] <= 1'b0;
        end else if (trip[i]) begin
          flt_q[i] <= 1'b1; // (RULE10)
        end
        if (st_d[i] == bfps_pkg::CH_RUN || st_d[i] == bfps_pkg::CH_OFF) begin
          rty_q[i] <= 3'h0;
        end else if (st_q[i] == bfps_pkg::CH_HIC && st_d[i] == bfps_pkg::CH_SS
                     && rty_q[i] != `BFPS_RETRY_MAX) begin
          rty_q[i] <= rty_q[i] + 3'h1; // (RULE13)
        end
      end
    end
  end

  // limit hit per switching cycle and fault counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cut_q <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        fcnt_q[i] <= 4'h0;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        // a hit in the tick cycle belongs to the new cycle
        cut_q[i] <= act[i] & (cmp_s[i].ilim_hit | (cut_q[i] & ~sw_tick));
        if (!act[i]) begin
          fcnt_q[i] <= 4'h0;
        end else if (sw_tick) begin
          // a clean cycle restarts the count; overflow wraps to zero
          fcnt_q[i] <= cut_q[i] ? fcnt_q[i] + 4'h1 : 4'h0; // (RULE8)
        end
      end
    end
  end

  // pulse skip phase, cycles through the divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        ph_q[i] <= 2'h0;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (!act[i]) begin
          ph_q[i] <= 2'h0;
        end else if (sw_tick) begin
          ph_q[i] <= (ph_q[i] >= div_f(cmp_s[i])) ? 2'h0 : ph_q[i] + 2'h1; // (RULE4) (RULE5) (RULE6) (RULE7)
        end
      end
    end
  end

  // gate drive and soft start outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_on         <= 4'h0;
      ls_on         <= 4'h0;
      reverse_block <= 4'h0;
      ss_active     <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        // diode emulation until the ramp passes a precharged output;
        // the next value is used so low side never overlaps the block
        reverse_block[i] <= rb_d[i]; // (RULE1)
        ss_active[i]     <= st_q[i] == bfps_pkg::CH_SS;
        if (!act[i]) begin
          hs_on[i] <= 1'b0; // (RULE8)
          ls_on[i] <= 1'b0;
        end else if (fire[i]) begin
          hs_on[i] <= 1'b1;
          ls_on[i] <= 1'b0;
        end else if (sw_tick || (hs_on[i] && (cmp_s[i].ilim_hit || cmp_s[i].pwm_end))) begin
          hs_on[i] <= 1'b0; // (RULE2)
          ls_on[i] <= ~rb_d[i]; // (RULE1) (RULE2)
        end else if (rb_d[i]) begin
          ls_on[i] <= 1'b0; // (RULE1)
        end
      end
    end
  end

  // power good and supervisor enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_good_output <= 1'b0;
      supervisor_active <= 1'b0;
    end else begin
      power_good_output <= (cfg_q[`BFPS_CFG_PGS_LSB +: 4] != 4'h0)
                           & (&(pg_val | ~cfg_q[`BFPS_CFG_PGS_LSB +: 4])); // (RULE20)
      supervisor_active <= |en_s; // (RULE22)
    end
  end

  // register read mux
  always_comb begin
    rd_d  = 32'h0000_0000;
    hit_d = 1'b1;
    case (paddr)
      `BFPS_CFG_OFS: rd_d = cfg_q;
      `BFPS_STAT_OFS: begin
        for (int i = 0; i < 4; i++) begin
          rd_d[i*3 +: 3] = st_q[i];
        end
        rd_d[`BFPS_STAT_PGF_LSB +: 4] = pg_flag;
        rd_d[`BFPS_STAT_PG_BIT]       = power_good_output;
        rd_d[`BFPS_STAT_TSD_BIT]      = tsd_q;
        rd_d[`BFPS_STAT_VOK_LSB +: 4] = vok_q;
        rd_d[`BFPS_STAT_SUP_BIT]      = supervisor_active;
      end
      `BFPS_STRAP_OFS: begin
        for (int i = 0; i < 4; i++) begin
          rd_d[i*2 +: 2] = ss_sel_q[i];
        end
        rd_d[`BFPS_STRAP_IL_LSB +: 4] = current_limit_setting;
      end
      `BFPS_FLT_OFS: begin
        for (int i = 0; i < 4; i++) begin
          rd_d[i*4 +: 4]                     = fcnt_q[i];
          rd_d[`BFPS_FLT_RTY_LSB + i*3 +: 3] = rty_q[i];
        end
      end
      default: hit_d = 1'b0;            // unmapped: error, data zero
    endcase
  end

  // apb slave: one access cycle, answer captured in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready <= psel & ~penable;
      if (psel && !penable) begin
        prdata  <= pwrite ? 32'h0000_0000 : rd_d;
        pslverr <= ~hit_d;
      end
    end
  end

  // configuration acts like fuses: the lock bit freezes it until the next reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= `BFPS_CFG_RST;
    end else if (psel && penable && pready && pwrite && paddr == `BFPS_CFG_OFS
                 && !cfg_q[`BFPS_CFG_LOCK_BIT]) begin
      cfg_q <= pwdata & `BFPS_CFG_MASK; // (RULE12) (RULE15)
    end
  end
endmodule

// ---- tb/bfps_stage.sv ----
// bfps power stage stand-in: comparators and switching tick
`timescale 1ns/100ps
module bfps_stage (
  input  logic                      pclk,
  input  logic [3:0]                hs_on,
  input  logic                      fault,
  input  logic                      vin_ok,
  input  logic                      pg,
  input  logic                      ovp,
  output logic                      sw_tick,
  output bfps_pkg::bfps_cmp_s [3:0] cmp
);
  logic [7:0] on_q = 8'h00; // two-clock high-side history
  logic [3:0] ph   = 4'h0;  // 16 clocks a period
  always_ff @(posedge pclk) begin
    on_q <= {on_q[3:0], hs_on};
    ph   <= ph + 4'h1;
  end
  assign sw_tick = ph == 4'h0;
  // fault: limit and deep foldback; output precharged above ramp until pg
  always_comb
    for (int i = 0; i < 4; i++)
      cmp[i] = '{fault, on_q[4+i] & ~fault, fault, fault, 1'b0, 1'b0, ovp,
                 vin_ok, ~vin_ok, pg, ~pg, pg};
endmodule

// ---- tb/bfps_sva.sv ----
// bfps checker on the top-level pins
`timescale 1ns/100ps
module bfps_sva (
  input logic                      pclk,
  input logic                      presetn,
  input bfps_pkg::bfps_cmp_s [3:0] cmp,
  input logic [3:0]                channel_enable_pin,
  input logic                      tsd_hot,
  input logic [3:0]                current_limit_strap,
  input logic [3:0]                hs_on,
  input logic [3:0]                ls_on,
  input logic [3:0]                reverse_block,
  input logic [3:0]                ss_active,
  input logic [3:0]                current_limit_setting,
  input logic                      power_good_output,
  input logic                      supervisor_active
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  AST_NO_SHOOT: assert property ((hs_on & ls_on) == 4'h0) else $error("shoot");
  AST_REV_BLOCK: assert property ((reverse_block & ls_on) == 4'h0) else $error("reverse");
  // strap code 3 unused, so setting equals strap
  AST_ILIM_CODE: assert property ($past(presetn) |->
    current_limit_setting == current_limit_strap) else $error("limit code");
  AST_UV_ALL: assert property (cmp[0].vin_fall [*6] |-> (hs_on | ls_on) == 4'h0)
    else $error("ch1 lockout");
  AST_TSD_OFF: assert property (tsd_hot [*6] |-> (hs_on | ls_on) == 4'h0) else $error("hot");
  AST_EN_OFF: assert property (!channel_enable_pin[0] [*6] |-> !hs_on[0] && !ss_active[0])
    else $error("disabled");
  AST_SS_EN: assert property ($rose(ss_active[0]) |-> $past(channel_enable_pin[0], 3))
    else $error("no enable");
  AST_PG_FALL: assert property (cmp[0].pg_fall [*8] ##1 cmp[0].pg_fall [*8]
    |-> !power_good_output) else $error("pg stuck");
  AST_SUP_IDLE: assert property ((channel_enable_pin == 4'h0) [*5] |-> !supervisor_active)
    else $error("idle");
  cover property ($rose(ss_active[0]));
  cover property ($rose(power_good_output));
  cover property (tsd_hot && supervisor_active);
endmodule
bind bfps_top bfps_sva u_sva (.*);

// ---- tb/test_buck_fault_protection_sequencer.sv ----
// bfps bench: apb reads checked from a queue, channel one scenarios
`timescale 1ns/100ps
`include "bfps_regs.svh"
module test_buck_fault_protection_sequencer;
  localparam int SS = 300; // room for sixteen limited ticks
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rnd = 32'h5C0AA652;
  logic pready, pslverr, sw_tick, pgo, tsd_hot = 1'b0, tsd_cool = 1'b1;
  logic flt = 1'b0, vin_ok = 1'b1, pg = 1'b0, ovp = 1'b0;
  logic [3:0] en = 4'h0, hs, ls, ssa;
  bfps_pkg::bfps_cmp_s [3:0] cmp;
  logic [63:0] q[$]; // mask and expected word of each read
  int n_errors = 0, compares = 0, cyc = 0, n;
  bfps_top #(.SS_CYC(SS), .PG_VAL(16), .PG_DEGL(5)) dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sw_tick(sw_tick), .cmp(cmp),
    .channel_enable_pin(en), .tsd_hot(tsd_hot), .tsd_cool(tsd_cool),
    .current_limit_strap(4'h9), .soft_start_strap_ch12(3'h0), .soft_start_strap_ch34(3'h0),
    .hs_on(hs), .ls_on(ls), .reverse_block(), .ss_active(ssa), .current_limit_setting(),
    .power_good_output(pgo), .supervisor_active());
  bfps_stage u_stage (.pclk(pclk), .hs_on(hs), .fault(flt), .vin_ok(vin_ok), .pg(pg),
    .ovp(ovp), .sw_tick(sw_tick), .cmp(cmp));
  initial forever #50 pclk = ~pclk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // hang guard, far above the longest run
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors++;
      conclude();
    end
  end
  // read results popped at the access edge; slave error shows as bit 31
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      chk((prdata & q[0][63:32]) | {pslverr, 31'h0}, q[0][31:0]);
      void'(q.pop_front());
    end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk); // idle edge between calls
  endtask
  task automatic st(input logic [31:0] e);
    rd(`BFPS_STAT_OFS, 32'h7, e);
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    q.push_back({m, e});
    apb(1'b0, a, 32'h0);
  endtask
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  // counts edges until soft start of channel one reaches a level
  task automatic wss(input logic v);
    n = 0;
    while (ssa[0] !== v && n < 30000) begin
      @(posedge pclk);
      n++;
    end
  endtask
  initial begin
    tick(3);
    presetn <= 1'b1;
    tick(1);
    rd(`BFPS_CFG_OFS, 32'hFFFFFFFF, `BFPS_CFG_RST);
    rd(8'h10, 32'hFFFFFFFF, 32'h80000000);
    for (int k = 0; k < 4; k++) begin
      rnd = xs(rnd);
      apb(1'b1, `BFPS_STRAP_OFS, rnd);
    end
    rd(`BFPS_STRAP_OFS, 32'hFFF, 32'h900);
    flt <= 1'b1;
    en <= {rnd[2:0], 1'b1};
    wss(1'b1);
    wss(1'b0);
    chk(n, SS);
    st(32'h2);
    wss(1'b1);
    chk(n >= 7 * SS, 1'b1);
    flt <= 1'b0;
    wss(1'b0);
    tick(600);
    st(32'h2);
    pg <= 1'b1;
    for (n = 0; pgo !== 1'b1 && n < 1000; n++) @(posedge pclk);
    chk(n >= 16 && n < 1000, 1'b1);
    pg <= 1'b0;
    tick(20);
    rd(`BFPS_STAT_OFS, 32'h10000, 32'h0);
    tsd_hot <= 1'b1;
    tsd_cool <= 1'b0;
    tick(8);
    rd(`BFPS_STAT_OFS, 32'h20000, 32'h20000);
    tsd_hot <= 1'b0;
    tsd_cool <= 1'b1;
    wss(1'b1);
    chk(n < 100, 1'b1);
    vin_ok <= 1'b0;
    tick(8);
    rd(`BFPS_STAT_OFS, 32'h3C0FFF, 32'h0);
    vin_ok <= 1'b1;
    apb(1'b1, `BFPS_CFG_OFS, 32'h80000017);
    apb(1'b1, `BFPS_CFG_OFS, 32'h00000011);
    rd(`BFPS_CFG_OFS, 32'hFFFFFFFF, 32'h80000017);
    tick(400);
    ovp <= 1'b1;
    tick(8);
    ovp <= 1'b0;
    tick(8);
    st(32'h4);
    en <= 4'h0;
    tick(8);
    st(32'h0);
    flt <= 1'b1;
    en <= 4'h1;
    repeat (8) begin
      wss(1'b1);
      wss(1'b0);
    end
    tick(2000);
    st(32'h4);
    conclude();
  end
endmodule
